// File: hdl/pmc_ctrl.sv
`timescale 1ns/100ps
`include "pmc_params.svh"
// Notes on behaviour
// - After power-on and reset release, enter main run when timebase wait ends.
// - External, software or watchdog reset returns main or sub run to reset.
// - Clock select 0 moves main to sub run; first time waits subclock stabilization.
// - Clock select 1 returns to main after main wait; monitor bit shows it.
// - Sleep write enters sleep in both modes; any interrupt or external reset releases.
// - Stop write enters stop; external interrupt releases after oscillator wait, external reset releases at once.
// - Watch write enters watch only from sub run; released by ext/watch irq or reset.
// - No software or watchdog reset is generated while in any standby state.
// - Single-clock part switching to subclock halts CPU until reset.
// - Standby writes are discarded while a peripheral request is pending; no deferral.
// - Standby entry allowed during servicing if no request is pending.
// - Sleep exits when any peripheral request arrives; stop exits only on the external interrupt or an external reset.
// - After wake, branch if level beats CPU level and enabled, else resume.
// - Several standby bits at once: stop wins, then watch, then sleep.
// - Watch bit writes are ignored while on the main clock.
// - Stop wake waits: one of three timebase waits in main, prescaler wait in sub.
// - Standby request bits always read as 0; writing 0 does nothing.
module pmc_ctrl
    import pmc_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         ce,
    input  wire logic                         ext_reset_b,
    input  wire logic                         ext_irq,
    input  wire logic                         dual_clock,
    input  wire logic                         ctl_write,
    input  wire logic [7:0]                   standby_control_reg,
    input  wire logic                         clk_sel_write,
    input  wire logic                         clock_select_bit,
    input  wire logic                         sw_reset_req,
    input  wire logic                         wdt_reset_req,
    input  wire logic                         periph_irq,
    input  wire logic                         watch_irq,
    input  wire logic [1:0]                   irq_level_setting_regs,
    input  wire logic [1:0]                   cpu_level_bits,
    input  wire logic                         irq_enable,
    input  wire logic [`PMC_WAIT_SEL_W-1:0]   wait_sel,
    input  wire logic [2:0]                   timebase_wait_end,
    input  wire logic                         prescaler_wait_end,
    output logic [7:0]                        standby_readback,
    output logic                              clock_monitor_bit,
    output logic                              cpu_clk_en,
    output logic                              wdt_clk_en,
    output logic                              main_osc_en,
    output logic                              sub_osc_en,
    output logic                              sys_reset,
    output logic                              wake_branch,
    output logic                              wake_resume,
    output logic [3:0]                        power_state
);

    ////////////////////////////////////////////////////////////////////////
    // Synchronised pins
    logic ext_rst_s;
    logic ext_irq_s;
    logic ext_rst_pin;

    assign ext_rst_pin = ~ext_reset_b;

    pmc_sync u_sync_rst (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .d     (ext_rst_pin),
        .q     (ext_rst_s)
    );

    pmc_sync u_sync_irq (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .d     (ext_irq),
        .q     (ext_irq_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // State record
    typedef struct packed {
        pmc_state_t  st;
        logic        sub_stable;
        logic        clk_mon;
        logic        clk_sel;
        logic [3:0]  swrst_cnt;
        logic        cpu_en;
        logic        wdt_en;
        logic        main_en;
        logic        sub_en;
        logic        rst_out;
        logic        branch;
        logic        resume;
        logic        stop_from_sub;
    } pmc_rec_t;

    pmc_rec_t cur_r;
    pmc_rec_t cur_nxt;
    pmc_req_t req;
    logic     irq_pending;
    logic     any_reset;
    logic     tb_end;
    logic     accept;

    // Pending request blocks entry, whether or not accepted
    assign irq_pending = periph_irq | ext_irq_s | watch_irq;
    assign tb_end      = timebase_wait_end[wait_sel];
    assign accept      = irq_enable & (irq_level_setting_regs < cpu_level_bits);

    ////////////////////////////////////////////////////////////////////////
    // Standby request decode
    always_comb begin
        req = PMC_REQ_NONE;
        if (ctl_write && standby_control_reg[`PMC_STANDBY_CONTROL_REG_STOP_BIT]) begin
            req = PMC_REQ_STOP;
        end else if (ctl_write && standby_control_reg[`PMC_STANDBY_CONTROL_REG_WATCH_BIT] && !cur_r.clk_sel) begin
            req = PMC_REQ_WATCH;
        end else if (ctl_write && standby_control_reg[`PMC_STANDBY_CONTROL_REG_SLEEP_BIT]) begin
            req = PMC_REQ_SLEEP;
        end
        if (irq_pending) begin
            req = PMC_REQ_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Run-state resets; standby states never see sw or wdt resets
    // no sw/wdt in standby
    assign any_reset = ext_rst_s
        | ((cur_r.st == PMC_MAIN_RUN || cur_r.st == PMC_SUB_RUN) && (sw_reset_req || wdt_reset_req));

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        cur_nxt        = cur_r;
        cur_nxt.branch = 1'b0;
        cur_nxt.resume = 1'b0;
        if (clk_sel_write) begin
            cur_nxt.clk_sel = clock_select_bit;
        end
        if (cur_r.swrst_cnt != 4'h0) begin
            cur_nxt.swrst_cnt = cur_r.swrst_cnt - 4'h1;
        end
        case (cur_r.st)
            PMC_RESET: begin
                if (!ext_rst_s && tb_end && cur_r.swrst_cnt == 4'h0) begin
                    cur_nxt.st      = PMC_MAIN_RUN;
                    cur_nxt.clk_mon = 1'b1;
                end
            end
            PMC_MAIN_RUN: begin
                if (!cur_r.clk_sel) begin
                    if (!dual_clock) begin
                        cur_nxt.st = PMC_HALT;
                    end else begin
                        cur_nxt.st = cur_r.sub_stable ? PMC_SUB_RUN : PMC_SUB_WAIT;
                        cur_nxt.clk_mon = ~cur_r.sub_stable;
                    end
                end else if (req == PMC_REQ_STOP) begin
                    cur_nxt.st = PMC_STOP;
                    cur_nxt.stop_from_sub = 1'b0;
                end else if (req == PMC_REQ_SLEEP) begin
                    cur_nxt.st = PMC_SLEEP;
                end
            end
            PMC_SUB_WAIT: begin
                if (prescaler_wait_end) begin
                    cur_nxt.st         = PMC_SUB_RUN;
                    cur_nxt.sub_stable = 1'b1;
                    cur_nxt.clk_mon    = 1'b0;
                end
            end
            PMC_SUB_RUN: begin
                if (cur_r.clk_sel) begin
                    cur_nxt.st = PMC_MAIN_WAIT;
                end else if (req == PMC_REQ_STOP) begin
                    cur_nxt.st = PMC_STOP;
                    cur_nxt.stop_from_sub = 1'b1;
                end else if (req == PMC_REQ_WATCH) begin
                    cur_nxt.st = PMC_WATCH;
                end else if (req == PMC_REQ_SLEEP) begin
                    cur_nxt.st = PMC_SLEEP;
                end
            end
            PMC_MAIN_WAIT: begin
                if (tb_end) begin
                    cur_nxt.st      = PMC_MAIN_RUN;
                    cur_nxt.clk_mon = 1'b1;
                end
            end
            PMC_SLEEP: begin
                if (irq_pending) begin
                    cur_nxt.st = cur_r.clk_mon ? PMC_MAIN_RUN : PMC_SUB_RUN;
                    cur_nxt.branch = accept;
                    cur_nxt.resume = ~accept;
                end
            end
            PMC_STOP: begin
                if (ext_irq_s) begin
                    cur_nxt.st = PMC_STOP_WAIT;
                end
            end
            PMC_STOP_WAIT: begin
                if (cur_r.stop_from_sub ? prescaler_wait_end : tb_end) begin
                    cur_nxt.st     = cur_r.stop_from_sub ? PMC_SUB_RUN : PMC_MAIN_RUN;
                    cur_nxt.branch = accept;
                    cur_nxt.resume = ~accept;
                end
            end
            PMC_WATCH: begin
                if (ext_irq_s || watch_irq) begin
                    cur_nxt.st     = PMC_SUB_RUN;
                    cur_nxt.branch = accept;
                    cur_nxt.resume = ~accept;
                end
            end
            PMC_HALT: begin
                cur_nxt.st = PMC_HALT;
            end
            default: begin
                cur_nxt.st = PMC_RESET;
            end
        endcase
        if (any_reset) begin
            cur_nxt.st      = PMC_RESET;
            cur_nxt.clk_sel = `PMC_CLKSEL_RST;
            cur_nxt.clk_mon = 1'b1;
            if (sw_reset_req && !ext_rst_s) begin
                cur_nxt.swrst_cnt = `PMC_SWRST_CYCLES;
            end
        end
        // CPU clock gated in waits and standby
        cur_nxt.cpu_en  = (cur_nxt.st == PMC_MAIN_RUN) || (cur_nxt.st == PMC_SUB_RUN);
        cur_nxt.wdt_en  = cur_nxt.cpu_en;
        cur_nxt.main_en = !(cur_nxt.st == PMC_STOP || cur_nxt.st == PMC_WATCH || cur_nxt.st == PMC_SUB_RUN
                            || (cur_nxt.st == PMC_STOP_WAIT && cur_nxt.stop_from_sub));
        cur_nxt.sub_en  = !(cur_nxt.st == PMC_STOP || cur_nxt.st == PMC_HALT
                            || (cur_nxt.st == PMC_STOP_WAIT && !cur_nxt.stop_from_sub));
        cur_nxt.rst_out = (cur_nxt.st == PMC_RESET);
    end

    ////////////////////////////////////////////////////////////////////////
    // Register the record; ce freezes everything
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_r <= '{st: PMC_RESET, sub_stable: 1'b0, clk_mon: 1'b1, clk_sel: 1'b1,
                       swrst_cnt: 4'h0, cpu_en: 1'b0, wdt_en: 1'b0, main_en: 1'b1,
                       sub_en: 1'b1, rst_out: 1'b1, branch: 1'b0, resume: 1'b0,
                       stop_from_sub: 1'b0};
        end else if (ce) begin
            cur_r <= cur_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops, except the constant readback
    // request bits read as 0
    assign standby_readback  = 8'h00;
    assign clock_monitor_bit = cur_r.clk_mon;
    assign cpu_clk_en        = cur_r.cpu_en;
    assign wdt_clk_en        = cur_r.wdt_en;
    assign main_osc_en       = cur_r.main_en;
    assign sub_osc_en        = cur_r.sub_en;
    assign sys_reset         = cur_r.rst_out;
    assign wake_branch       = cur_r.branch;
    assign wake_resume       = cur_r.resume;
    assign power_state       = cur_r.st;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_stop_gate;
        @(posedge clk) disable iff (!rst_b)
        (ce && cur_r.st == PMC_MAIN_RUN && irq_pending && !any_reset && cur_r.clk_sel) |=> (cur_r.st == PMC_MAIN_RUN);
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("standby entered with pending irq");

    property p_cpu_gated;
        @(posedge clk) disable iff (!rst_b)
        (cur_r.st == PMC_STOP_WAIT || cur_r.st == PMC_MAIN_WAIT || cur_r.st == PMC_SUB_WAIT) |-> !cpu_clk_en;
    endproperty
    a_cpu_gated: assert property (p_cpu_gated) else $error("cpu clock on during wait");

    property p_watch_main;
        @(posedge clk) disable iff (!rst_b)
        (cur_r.st == PMC_MAIN_RUN) |=> (cur_r.st != PMC_WATCH);
    endproperty
    a_watch_main: assert property (p_watch_main) else $error("watch entered from main");

    property p_halt_sticky;
        @(posedge clk) disable iff (!rst_b)
        (cur_r.st == PMC_HALT && !ext_rst_s) |=> (cur_r.st == PMC_HALT);
    endproperty
    a_halt_sticky: assert property (p_halt_sticky) else $error("halt left without reset");

    property p_stop_prio;
        @(posedge clk) disable iff (!rst_b)
        (ce && req != PMC_REQ_NONE && ctl_write && standby_control_reg[`PMC_STANDBY_CONTROL_REG_STOP_BIT]) |-> (req == PMC_REQ_STOP);
    endproperty
    a_stop_prio: assert property (p_stop_prio) else $error("stop lost priority");

    property p_sleep_wake;
        @(posedge clk) disable iff (!rst_b)
        (ce && cur_r.st == PMC_SLEEP && irq_pending && !any_reset) |=> (wake_branch ^ wake_resume);
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not exited on irq");

    property p_standby_no_sw;
        @(posedge clk) disable iff (!rst_b)
        (ce && cur_r.st == PMC_WATCH && !ext_rst_s && !ext_irq_s && !watch_irq) |=> (cur_r.st == PMC_WATCH);
    endproperty
    a_standby_no_sw: assert property (p_standby_no_sw) else $error("watch left without cause");

    property p_main_mon;
        @(posedge clk) disable iff (!rst_b)
        (ce && cur_r.st == PMC_MAIN_WAIT && tb_end && !any_reset) |=> (clock_monitor_bit && cur_r.st == PMC_MAIN_RUN);
    endproperty
    a_main_mon: assert property (p_main_mon) else $error("monitor not set after main wait");

endmodule // pmc_ctrl

// File: hdl/pmc_params.svh
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
// Standby control word bit positions
`define PMC_STANDBY_CONTROL_REG_STOP_BIT   7
`define PMC_STANDBY_CONTROL_REG_SLEEP_BIT  6
`define PMC_STANDBY_CONTROL_REG_WATCH_BIT  3
// Software reset stretch, in cycles
`define PMC_SWRST_CYCLES    4'h4
// Reset value of the clock select (main clock)
`define PMC_CLKSEL_RST      1'b1
// Width of the stabilization wait selector (three choices)
`define PMC_WAIT_SEL_W      2
`endif

// File: hdl/pmc_pkg.sv
package pmc_pkg;
    typedef enum logic [3:0] {
        PMC_RESET     = 4'h0,
        PMC_MAIN_RUN  = 4'h1,
        PMC_SUB_WAIT  = 4'h2,
        PMC_SUB_RUN   = 4'h3,
        PMC_MAIN_WAIT = 4'h4,
        PMC_SLEEP     = 4'h5,
        PMC_STOP      = 4'h6,
        PMC_STOP_WAIT = 4'h7,
        PMC_WATCH     = 4'h8,
        PMC_HALT      = 4'h9
    } pmc_state_t;

    typedef enum logic [1:0] {
        PMC_REQ_NONE  = 2'h0,
        PMC_REQ_SLEEP = 2'h1,
        PMC_REQ_WATCH = 2'h2,
        PMC_REQ_STOP  = 2'h3
    } pmc_req_t;
endpackage

// File: hdl/pmc_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser; first stage feeds only the second
module pmc_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    // Double flop for asynchronous pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // pmc_sync

// File: dv/dual_clock_power_mode_control_test.sv
`timescale 1ns/100ps
`include "pmc_params.svh"
module dual_clock_power_mode_control_test;
    import pmc_pkg::*;

    logic                        clk;
    logic                        rst_b;
    logic                        ce;
    logic                        ext_reset_b;
    logic                        ext_irq;
    logic                        dual_clock;
    logic                        ctl_write;
    logic [7:0]                  standby_control_reg;
    logic                        clk_sel_write;
    logic                        clock_select_bit;
    logic                        sw_reset_req;
    logic                        wdt_reset_req;
    logic                        periph_irq;
    logic                        watch_irq;
    logic [1:0]                  irq_level_setting_regs;
    logic [1:0]                  cpu_level_bits;
    logic                        irq_enable;
    logic [`PMC_WAIT_SEL_W-1:0]  wait_sel;
    logic [2:0]                  timebase_wait_end;
    logic                        prescaler_wait_end;
    logic [7:0]                  standby_readback;
    logic                        clock_monitor_bit;
    logic                        cpu_clk_en;
    logic                        wdt_clk_en;
    logic                        main_osc_en;
    logic                        sub_osc_en;
    logic                        sys_reset;
    logic                        wake_branch;
    logic                        wake_resume;
    logic [3:0]                  power_state;
    int                          miscompares;
    int                          total_checks;

    pmc_ctrl uut (
        .clk(clk), .rst_b(rst_b), .ce(ce), .ext_reset_b(ext_reset_b), .ext_irq(ext_irq),
        .dual_clock(dual_clock), .ctl_write(ctl_write), .standby_control_reg(standby_control_reg),
        .clk_sel_write(clk_sel_write), .clock_select_bit(clock_select_bit),
        .sw_reset_req(sw_reset_req), .wdt_reset_req(wdt_reset_req), .periph_irq(periph_irq),
        .watch_irq(watch_irq), .irq_level_setting_regs(irq_level_setting_regs),
        .cpu_level_bits(cpu_level_bits), .irq_enable(irq_enable), .wait_sel(wait_sel),
        .timebase_wait_end(timebase_wait_end), .prescaler_wait_end(prescaler_wait_end),
        .standby_readback(standby_readback), .clock_monitor_bit(clock_monitor_bit),
        .cpu_clk_en(cpu_clk_en), .wdt_clk_en(wdt_clk_en), .main_osc_en(main_osc_en),
        .sub_osc_en(sub_osc_en), .sys_reset(sys_reset), .wake_branch(wake_branch),
        .wake_resume(wake_resume), .power_state(power_state)
    );

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // A setting at or above the CPU level loses, so only a strictly lower setting branches
    function automatic logic branch_exp(logic [1:0] lvl, logic [1:0] cpu, logic en);
        return en && (lvl < cpu);
    endfunction

    task automatic report_and_stop;
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Inputs only ever move at the falling edge
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait; a hang ends the run with a mismatch
    task automatic wait_st(input pmc_state_t s);
        int i;
        for (i = 0; i < 64 && power_state !== s; i++)
            step(1);
        check(power_state, s);
        if (power_state !== s)
            report_and_stop();
    endtask

    // Unused low bits get random filler, they must not matter
    task automatic wr(input logic [7:0] d);
        ctl_write = 1'b1;
        standby_control_reg = d | 8'($urandom_range(7));
        step(1);
        ctl_write = 1'b0;
        // Idle cycle so back-to-back writes never retoggle the strobe at once
        step(1);
    endtask

    task automatic sel(input logic b);
        clk_sel_write = 1'b1;
        clock_select_bit = b;
        step(1);
        clk_sel_write = 1'b0;
    endtask

    task automatic wake_periph(input pmc_state_t run, input logic [1:0] lvl,
                               input logic [1:0] cpu, input logic en);
        logic exp_br;
        irq_level_setting_regs = lvl;
        cpu_level_bits = cpu;
        irq_enable = en;
        exp_br = branch_exp(lvl, cpu, en);
        periph_irq = 1'b1;
        step(1);
        check(power_state, run);
        check(wake_branch, exp_br);
        check(wake_resume, !exp_br);
        periph_irq = 1'b0;
        step(1);
        check({wake_branch, wake_resume}, 8'h00);
    endtask

    // External reset pin pulse, then back to main run
    task automatic pin_reset;
        ext_reset_b = 1'b0;
        wait_st(PMC_RESET);
        ext_reset_b = 1'b1;
        wait_st(PMC_MAIN_RUN);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, ext_irq, ctl_write, standby_control_reg, clk_sel_write} = '0;
        {sw_reset_req, wdt_reset_req, periph_irq, watch_irq, irq_enable} = '0;
        {irq_level_setting_regs, cpu_level_bits, wait_sel, timebase_wait_end} = '0;
        {prescaler_wait_end, miscompares, total_checks} = '0;
        {ce, ext_reset_b, dual_clock, clock_select_bit} = 4'hf;
        void'($urandom(32'ha8bc8dde));
        step(10);
        check(sys_reset, 1'b1);
        check(cpu_clk_en, 1'b0);
        check(clock_monitor_bit, 1'b1);
        rst_b = 1'b1;
        wait_sel = 2'($urandom_range(2));
        step(8);
        check(power_state, PMC_RESET);
        check(cpu_clk_en, 1'b0);
        timebase_wait_end = 3'h1 << wait_sel;
        wait_st(PMC_MAIN_RUN);
        check(sys_reset, 1'b0);
        check(cpu_clk_en, 1'b1);
        for (int k = 0; k < 6; k++) begin
            wr(8'h40);
            check(power_state, PMC_SLEEP);
            check({cpu_clk_en, wdt_clk_en}, 8'h00);
            check(standby_readback, 8'h00);
            {sw_reset_req, wdt_reset_req} = 2'b11;
            step(3);
            check(power_state, PMC_SLEEP);
            {sw_reset_req, wdt_reset_req} = 2'b00;
            if (k == 0)
                wake_periph(PMC_MAIN_RUN, 2'h2, 2'h2, 1'b1);
            else
                wake_periph(PMC_MAIN_RUN, 2'($urandom), 2'($urandom), 1'($urandom));
        end
        // pending request drops writes, no deferral
        periph_irq = 1'b1;
        wr(8'h80);
        wr(8'h40);
        periph_irq = 1'b0;
        step(4);
        check(power_state, PMC_MAIN_RUN);
        wr(8'h08);
        check(power_state, PMC_MAIN_RUN);
        wr(8'h48);
        check(power_state, PMC_SLEEP);
        wake_periph(PMC_MAIN_RUN, 2'h0, 2'h3, 1'b0);
        // stop with each of the three waits
        for (int w = 0; w < 3; w++) begin
            timebase_wait_end = 3'h0;
            wait_sel = 2'(w);
            wr(8'hc8);
            check(power_state, PMC_STOP);
            check({main_osc_en, sub_osc_en}, 8'h00);
            ext_irq = 1'b1;
            wait_st(PMC_STOP_WAIT);
            ext_irq = 1'b0;
            timebase_wait_end = ~(3'h1 << w);
            step(3);
            check(power_state, PMC_STOP_WAIT);
            check(cpu_clk_en, 1'b0);
            timebase_wait_end = 3'h7;
            wait_st(PMC_MAIN_RUN);
        end
        // first switch to sub waits for the subclock
        step(4);
        sel(1'b0);
        wait_st(PMC_SUB_WAIT);
        step(4);
        check(power_state, PMC_SUB_WAIT);
        prescaler_wait_end = 1'b1;
        wait_st(PMC_SUB_RUN);
        check(clock_monitor_bit, 1'b0);
        check({main_osc_en, sub_osc_en}, 8'h01);
        wr(8'h40);
        check(power_state, PMC_SLEEP);
        wake_periph(PMC_SUB_RUN, 2'($urandom), 2'($urandom), 1'b1);
        // watch entry and both release sources
        wr(8'h48);
        check(power_state, PMC_WATCH);
        watch_irq = 1'b1;
        wait_st(PMC_SUB_RUN);
        watch_irq = 1'b0;
        wr(8'h08);
        check(power_state, PMC_WATCH);
        ext_irq = 1'b1;
        wait_st(PMC_SUB_RUN);
        ext_irq = 1'b0;
        step(4);
        // sub stop waits on the prescaler only
        prescaler_wait_end = 1'b0;
        wr(8'h80);
        check(power_state, PMC_STOP);
        ext_irq = 1'b1;
        wait_st(PMC_STOP_WAIT);
        ext_irq = 1'b0;
        step(3);
        check(power_state, PMC_STOP_WAIT);
        prescaler_wait_end = 1'b1;
        wait_st(PMC_SUB_RUN);
        step(4);
        // back to main after the main wait
        timebase_wait_end = 3'h0;
        sel(1'b1);
        wait_st(PMC_MAIN_WAIT);
        step(3);
        check({power_state, clock_monitor_bit}, {PMC_MAIN_WAIT, 1'b0});
        timebase_wait_end = 3'h7;
        wait_st(PMC_MAIN_RUN);
        check(clock_monitor_bit, 1'b1);
        check({main_osc_en, sub_osc_en}, 8'h03);
        wr(8'h40);
        check(power_state, PMC_SLEEP);
        wake_periph(PMC_MAIN_RUN, 2'($urandom), 2'($urandom), 1'($urandom));
        sw_reset_req = 1'b1;
        step(1);
        sw_reset_req = 1'b0;
        wait_st(PMC_RESET);
        check(sys_reset, 1'b1);
        wait_st(PMC_MAIN_RUN);
        sel(1'b0);
        wait_st(PMC_SUB_RUN);
        wdt_reset_req = 1'b1;
        step(1);
        wdt_reset_req = 1'b0;
        wait_st(PMC_RESET);
        wait_st(PMC_MAIN_RUN);
        pin_reset();
        // pin reset out of sleep and stop
        wr(8'h40);
        pin_reset();
        wr(8'h80);
        check(power_state, PMC_STOP);
        pin_reset();
        // single clock part halts on sub switch
        dual_clock = 1'b0;
        sel(1'b0);
        wait_st(PMC_HALT);
        step(5);
        check({power_state, cpu_clk_en}, {PMC_HALT, 1'b0});
        dual_clock = 1'b1;
        pin_reset();
        report_and_stop();
    end
endmodule // dual_clock_power_mode_control_test
